/* File: rtl/asu_pkg.sv */
// Purpose: shared constants for the asynchronous serial unit
// Assumes: 25 MHz core clock, plain register port with 3-bit address
// Notes: register offsets and bit positions are fixed here only
package asu_pkg;
    localparam int DIV_W = 13;
    localparam int OVS = 16;
    localparam int START_ONES = 3;
    localparam logic [2:0] OFS_RATE = 3'h0;
    localparam logic [2:0] OFS_CFG = 3'h1;
    localparam logic [2:0] OFS_STAT = 3'h2;
    localparam logic [2:0] OFS_DATA = 3'h3;
    localparam logic [2:0] OFS_STDA = 3'h4;
    localparam logic [2:0] OFS_PIN = 3'h5;
    // config bits
    localparam int C_RE = 0;
    localparam int C_TE = 1;
    localparam int C_M = 2;
    localparam int C_PE = 3;
    localparam int C_PT = 4;
    localparam int C_SBK = 5;
    localparam int C_WAKE = 6;
    localparam int C_TIE = 7;
    localparam int C_TCIE = 8;
    localparam int C_RIE = 9;
    // status bits
    localparam int S_PF = 0;
    localparam int S_FE = 1;
    localparam int S_NF = 2;
    localparam int S_OR = 3;
    localparam int S_IDLE = 4;
    localparam int S_RAF = 5;
    localparam int S_RX_HOLDING_FULL = 6;
    localparam int S_TC = 7;
    localparam int S_TX_HOLDING_EMPTY = 8;
    localparam logic [15:0] RX_FLAGS = 16'h007f;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] RATE_RST = 16'h0004;
    localparam logic [15:0] STAT_RST = 16'h0180;
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam logic [3:0] MID_TICK = 4'h7;
endpackage

/* File: rtl/asu_baud.sv */
// Purpose: sampling tick and bit strobe generator
// Assumes: divisor stable while enabled
// Notes: zero divisor halts everything
`timescale 1ns/1ps
`default_nettype none
module asu_baud
    import asu_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic tick_o,
    output logic bit_o
);
    typedef struct packed {
        logic [DIV_W:0] cnt;
        logic [3:0] sub;
        logic tick;
        logic bit_s;
    } asu_baud_s;
    asu_baud_s st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        nxt_st.bit_s = 1'b0;
        if (div_i == '0) begin // R02
            nxt_st.cnt = '0;
            nxt_st.sub = '0;
        end else if (st_ff.cnt >= {div_i, 1'b0} - 1'b1) begin // R24 R01
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
            nxt_st.sub = st_ff.sub + 4'h1; // R04
            nxt_st.bit_s = (st_ff.sub == LAST_TICK);
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;
    assign bit_o = st_ff.bit_s;

    property p_stop;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (div_i == '0) |=> !tick_o;
    endproperty
    a_stop: assert property (p_stop) else $error("tick while divisor zero"); // R02
    property p_gap;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (tick_o && div_i > 13'h0001 && $stable(div_i)) |=> !tick_o;
    endproperty
    a_gap: assert property (p_gap) else $error("ticks too close"); // R24
endmodule
`default_nettype wire

/* File: rtl/asu_rx.sv */
// Purpose: receiver with 16x oversampling
// Assumes: line already synchronous to core clock
// Notes: majority of three middle samples decides each bit
`timescale 1ns/1ps
`default_nettype none
module asu_rx
    import asu_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic tick_i,
    input wire logic line_i,
    input wire logic [3:0] nbits_i,
    output logic done_o,
    output logic [9:0] frame_o,
    output logic noise_o,
    output logic stop_ok_o,
    output logic brk_o,
    output logic idle_o,
    output logic busy_o
);
    typedef enum logic [2:0] {
        RX_HUNT = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } asu_rx_e;
    typedef struct packed {
        asu_rx_e state;
        logic [1:0] ones;
        logic [3:0] ph;
        logic [3:0] idx;
        logic [9:0] sh;
        logic [2:0] smp;
        logic noise;
        logic done;
        logic stop_ok;
        logic brk;
        logic idle;
        logic [3:0] idle_cnt;
        logic [3:0] idle_bits;
    } asu_rx_s;
    asu_rx_s st_ff, nxt_st;

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    always_comb begin
        logic b;
        b = maj3(st_ff.smp);
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.idle = 1'b0;
        if (!en_i) begin
            nxt_st.state = RX_HUNT;
            nxt_st.ones = '0;
        end else if (tick_i) begin
            if (line_i) begin
                nxt_st.idle_cnt = st_ff.idle_cnt + 4'h1;
                if (st_ff.idle_cnt == LAST_TICK) begin
                    nxt_st.idle_bits = st_ff.idle_bits + 4'h1;
                    if (st_ff.idle_bits == nbits_i) begin // R08
                        nxt_st.idle = st_ff.state == RX_HUNT;
                        nxt_st.idle_bits = '0;
                    end
                end
            end else begin
                nxt_st.idle_cnt = '0;
                nxt_st.idle_bits = '0;
            end
            case (st_ff.state)
                RX_HUNT: begin
                    if (line_i) begin
                        nxt_st.ones = (st_ff.ones == 2'h3) ? st_ff.ones : st_ff.ones + 2'h1;
                    end else if (st_ff.ones >= 2'(START_ONES)) begin // R06
                        nxt_st.state = RX_START;
                        nxt_st.ph = 4'h1; // R05
                        nxt_st.idx = '0;
                        // start from zero so the break test sees this frame's bits only
                        nxt_st.sh = '0;
                        nxt_st.noise = 1'b0;
                    end else begin
                        nxt_st.ones = '0;
                    end
                end
                RX_START, RX_DATA: begin
                    nxt_st.ph = st_ff.ph + 4'h1;
                    if (st_ff.ph >= MID_TICK - 4'h1 && st_ff.ph <= MID_TICK + 4'h1) begin
                        nxt_st.smp = {st_ff.smp[1:0], line_i};
                    end
                    if (st_ff.ph == MID_TICK + 4'h2) begin
                        if (st_ff.smp != 3'h0 && st_ff.smp != 3'h7) begin
                            nxt_st.noise = 1'b1;
                        end
                        if (st_ff.state == RX_START) begin
                            if (b) begin
                                nxt_st.state = RX_HUNT; // false start
                                nxt_st.ones = '0;
                            end else begin
                                nxt_st.state = RX_DATA;
                            end
                        end else begin
                            nxt_st.sh = {b, st_ff.sh[9:1]}; // R11
                            nxt_st.idx = st_ff.idx + 4'h1;
                            if (st_ff.idx == nbits_i - 4'h1) begin // R07
                                nxt_st.state = RX_HUNT;
                                nxt_st.ones = b ? 2'h1 : 2'h0;
                                nxt_st.done = 1'b1;
                                nxt_st.stop_ok = b;
                                nxt_st.brk = !b && st_ff.sh[9:1] == '0; // R09
                            end
                        end
                    end
                end
                default: nxt_st.state = RX_HUNT;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_ff <= '{state: RX_HUNT, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;
    assign frame_o = st_ff.sh;
    assign noise_o = st_ff.noise;
    assign stop_ok_o = st_ff.stop_ok;
    assign brk_o = st_ff.brk;
    assign idle_o = st_ff.idle;
    assign busy_o = st_ff.state != RX_HUNT;

    property p_start;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (st_ff.state == RX_START && $past(st_ff.state) == RX_HUNT) |->
            $past(st_ff.ones) >= 2'(START_ONES);
    endproperty
    a_start: assert property (p_start) else $error("start without three ones"); // R06
    property p_stopbit;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (done_o && stop_ok_o) |-> frame_o[9];
    endproperty
    a_stopbit: assert property (p_stopbit) else $error("stop flag without high stop"); // R07
endmodule
`default_nettype wire

/* File: rtl/asu_top.sv */
// Purpose: asynchronous serial unit, registers, transmitter and flag logic
// Assumes: register port strobes are single cycle and never overlap
// Notes: status read arms a clear that the next data access performs
//
// Summary of operation
// R01: bit rate is core clock over thirty-two times the 13-bit divisor
// R02: zero divisor stops the rate generator
// R03: software uses divisors one to 8191 when active
// R04: sampling clock runs at sixteen times the bit rate
// R05: receiver realigns its sample points on each start edge
// R06: start needs a falling edge after three high samples
// R07: every frame has a start bit and at least one high stop bit
// R08: a full frame of ones is an idle frame
// R09: a full frame of zeros with no stop is a break frame
// R10: length bit selects ten or eleven bit frames
// R11: data goes least significant bit first, both ends same format
// R12: flags clear by hardware or status read then data access
// R13: combined status-data read clears rx flags, not tx flags
// R14: flag set after the status read survives the data access
// R15: reading any byte of status arms all flags
// R16: data address reads rx holding, writes tx holding; ninth bit optional
// R17: transmit pin is general I/O while the transmitter is off
// R18: config register always accessible; hardware may alter wakeup bit
// R19: software programs divisor before enabling either direction
// R20: software should disable before changing settings
// R21: flags support polling; enable bits gate request outputs
// R22: parity takes the top data bit; four data/parity combinations
// R23: stop bit loads rx holding; full holding gives overrun
// R24: tick every twice-divisor clocks, bit strobe every sixteenth tick
`timescale 1ns/1ps
`default_nettype none
module asu_top
    import asu_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic txd_oe_o,
    input wire logic txd_gpio_i,
    output logic tx_req_o,
    output logic rx_req_o
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_PRE = 4'b0010,
        TX_DATA = 4'b0100,
        TX_BRK = 4'b1000
    } asu_tx_e;
    typedef struct packed {
        logic [15:0] rate;
        logic [15:0] cfg;
        logic [15:0] stat;
        logic [15:0] armed;
        logic [8:0] rx_hold;
        logic [8:0] tx_hold;
        logic [15:0] pin;
        logic [15:0] rdata;
        asu_tx_e txs;
        logic [10:0] tsh;
        logic [3:0] tcnt;
        logic te_q;
        logic mark;
    } asu_top_s;
    asu_top_s st_ff, nxt_st;

    logic tick, bstb, rx_done, rx_noise, rx_stop, rx_brk, rx_idle, rx_busy;
    logic [9:0] rx_frame;
    logic [3:0] nbits;

    function automatic logic odd9(input logic [8:0] v);
        return ^v;
    endfunction

    asu_baud u_baud (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .div_i(st_ff.rate[DIV_W-1:0]),
        .tick_o(tick),
        .bit_o(bstb)
    );

    // bits after start: 9 or 10 for the two frame lengths
    assign nbits = st_ff.cfg[C_M] ? 4'ha : 4'h9; // R10

    asu_rx u_rx (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .en_i(st_ff.cfg[C_RE]),
        .tick_i(tick),
        .line_i(rxd_i),
        .nbits_i(nbits),
        .done_o(rx_done),
        .frame_o(rx_frame),
        .noise_o(rx_noise),
        .stop_ok_o(rx_stop),
        .brk_o(rx_brk),
        .idle_o(rx_idle),
        .busy_o(rx_busy)
    );

    always_comb begin
        logic [8:0] rdat;
        logic [15:0] setv;
        logic [15:0] clrv;
        logic pbit;
        logic data_acc;
        logic [8:0] td;
        rdat = '0;
        setv = '0;
        clrv = '0;
        pbit = 1'b0;
        td = '0;
        nxt_st = st_ff;
        data_acc = (rd_i || wr_i) && (addr_i == OFS_DATA);
        // receive frame unpacking; stop bit sits on top, data bits below it
        if (st_ff.cfg[C_M]) begin
            rdat = rx_frame[8:0];
        end else begin
            rdat = {1'b0, rx_frame[8:1]};
        end
        if (rx_done) begin // R23
            if (st_ff.stat[S_RX_HOLDING_FULL] && !(data_acc && st_ff.armed[S_RX_HOLDING_FULL])) begin
                setv[S_OR] = 1'b1;
            end else begin
                nxt_st.rx_hold = rdat;
                setv[S_RX_HOLDING_FULL] = 1'b1;
                setv[S_FE] = !rx_stop || rx_brk; // R09
                setv[S_NF] = rx_noise;
                if (st_ff.cfg[C_PE]) begin // R22
                    pbit = st_ff.cfg[C_M] ? odd9({1'b0, rdat[7:0]}) : odd9({2'b0, rdat[6:0]});
                    setv[S_PF] = (pbit ^ st_ff.cfg[C_PT]) != (st_ff.cfg[C_M] ? rdat[8] : rdat[7]);
                end
                // wakeup ends once a frame is taken
                nxt_st.cfg[C_WAKE] = 1'b0; // R18
            end
        end
        setv[S_IDLE] = rx_idle; // R08
        setv[S_RAF] = 1'b0;
        // the armed set is cleared on the data access or a combined status-data read
        if (data_acc) begin // R12
            clrv = st_ff.armed & RX_FLAGS;
            if (wr_i) begin
                clrv[S_TX_HOLDING_EMPTY] = st_ff.armed[S_TX_HOLDING_EMPTY];
                clrv[S_TC] = st_ff.armed[S_TC];
            end
            nxt_st.armed = '0;
        end
        if (rd_i && addr_i == OFS_STAT) begin // R15
            nxt_st.armed = st_ff.stat; // R14
        end
        if (rd_i && addr_i == OFS_STDA) begin // R13
            clrv = st_ff.stat & RX_FLAGS;
            nxt_st.armed = '0;
        end
        nxt_st.stat = (st_ff.stat & ~clrv) | setv;
        nxt_st.stat[S_RAF] = rx_busy;
        // register writes
        if (wr_i) begin
            case (addr_i)
                OFS_RATE: nxt_st.rate = wdata_i & {3'h0, {DIV_W{1'b1}}}; // R03
                OFS_CFG: nxt_st.cfg = wdata_i;
                OFS_DATA: begin // R16
                    nxt_st.tx_hold = wdata_i[8:0];
                    nxt_st.stat[S_TX_HOLDING_EMPTY] = 1'b0;
                end
                OFS_PIN: nxt_st.pin = wdata_i;
                default: nxt_st.rate = st_ff.rate;
            endcase
        end
        // read data, one cycle later
        nxt_st.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                OFS_RATE: nxt_st.rdata = st_ff.rate;
                OFS_CFG: nxt_st.rdata = st_ff.cfg; // R18
                OFS_STAT: nxt_st.rdata = st_ff.stat; // R21
                OFS_DATA: nxt_st.rdata = {7'h00, st_ff.rx_hold};
                OFS_STDA: nxt_st.rdata = {7'h00, st_ff.rx_hold};
                OFS_PIN: nxt_st.rdata = st_ff.pin;
                default: nxt_st.rdata = '0;
            endcase
        end
        // transmitter
        nxt_st.te_q = st_ff.cfg[C_TE];
        if (st_ff.cfg[C_TE] && !st_ff.te_q) begin
            nxt_st.mark = 1'b1;
        end
        if (bstb) begin
            case (st_ff.txs)
                TX_IDLE: begin
                    if (st_ff.cfg[C_TE]) begin
                        if (st_ff.mark) begin
                            nxt_st.txs = TX_PRE;
                            nxt_st.tcnt = nbits;
                            nxt_st.tsh = '1;
                            nxt_st.mark = 1'b0;
                        end else if (st_ff.cfg[C_SBK]) begin
                            nxt_st.txs = TX_BRK;
                            nxt_st.tcnt = nbits;
                            nxt_st.tsh = '0;
                        end else if (!st_ff.stat[S_TX_HOLDING_EMPTY]) begin
                            td = st_ff.tx_hold;
                            if (st_ff.cfg[C_PE]) begin // R22
                                if (st_ff.cfg[C_M]) begin
                                    td[8] = odd9({1'b0, td[7:0]}) ^ st_ff.cfg[C_PT];
                                end else begin
                                    td[7] = odd9({2'b0, td[6:0]}) ^ st_ff.cfg[C_PT];
                                end
                            end
                            // start low then data lsb first then stop high
                            nxt_st.tsh = st_ff.cfg[C_M] ? {1'b1, td, 1'b0} : {2'b11, td[7:0], 1'b0}; // R11 R07
                            nxt_st.txs = TX_DATA;
                            nxt_st.tcnt = nbits;
                            nxt_st.stat[S_TX_HOLDING_EMPTY] = 1'b1;
                            nxt_st.stat[S_TC] = 1'b0;
                        end else begin
                            nxt_st.stat[S_TC] = 1'b1;
                        end
                    end
                end
                TX_PRE, TX_DATA, TX_BRK: begin
                    nxt_st.tsh = {1'b1, st_ff.tsh[10:1]};
                    nxt_st.tcnt = st_ff.tcnt - 4'h1;
                    if (st_ff.tcnt == '0) begin
                        nxt_st.txs = TX_IDLE;
                        nxt_st.mark = st_ff.txs == TX_BRK;
                        nxt_st.stat[S_TC] = st_ff.txs != TX_DATA;
                    end
                end
                default: nxt_st.txs = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_ff <= '{rate: RATE_RST, cfg: CFG_RST, stat: STAT_RST, txs: TX_IDLE,
                       tsh: '1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // transmitter owns the pin while enabled or still shifting
    assign txd_oe_o = st_ff.cfg[C_TE] || st_ff.txs != TX_IDLE || st_ff.pin[0]; // R17
    assign txd_o = (st_ff.cfg[C_TE] || st_ff.txs != TX_IDLE) ? st_ff.tsh[0] : txd_gpio_i;
    assign rdata_o = st_ff.rdata;
    assign tx_req_o = (st_ff.cfg[C_TIE] && st_ff.stat[S_TX_HOLDING_EMPTY])
                    || (st_ff.cfg[C_TCIE] && st_ff.stat[S_TC]); // R21
    assign rx_req_o = st_ff.cfg[C_RIE] && st_ff.stat[S_RX_HOLDING_FULL];

    sequence s_arm;
        rd_i && addr_i == OFS_STAT && st_ff.stat[S_RX_HOLDING_FULL];
    endsequence
    sequence s_dacc;
        rd_i && addr_i == OFS_DATA && !rx_done;
    endsequence
    property p_clear;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        s_arm ##1 s_dacc |=> !st_ff.stat[S_RX_HOLDING_FULL];
    endproperty
    a_clear: assert property (p_clear) else $error("rx_holding_full not cleared"); // R12
    property p_long;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (rd_i && addr_i == OFS_STDA && !bstb) |=>
            st_ff.stat[S_TX_HOLDING_EMPTY] == $past(st_ff.stat[S_TX_HOLDING_EMPTY]);
    endproperty
    a_long: assert property (p_long) else $error("long read touched tx_holding_empty"); // R13
    property p_survive;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (rd_i && addr_i == OFS_DATA && st_ff.stat[S_RX_HOLDING_FULL] && !st_ff.armed[S_RX_HOLDING_FULL]) |=>
            st_ff.stat[S_RX_HOLDING_FULL];
    endproperty
    a_survive: assert property (p_survive) else $error("late flag lost"); // R14
    property p_load;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (rx_done && !st_ff.stat[S_RX_HOLDING_FULL]) |=> st_ff.stat[S_RX_HOLDING_FULL];
    endproperty
    a_load: assert property (p_load) else $error("rx_holding_full not set"); // R23
    property p_pin;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!st_ff.cfg[C_TE] && st_ff.txs == TX_IDLE) |-> txd_o == txd_gpio_i;
    endproperty
    a_pin: assert property (p_pin) else $error("pin not released"); // R17
    property p_rdata;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (rd_i && addr_i == OFS_CFG) |=> rdata_o == $past(st_ff.cfg);
    endproperty
    a_rdata: assert property (p_rdata) else $error("config readback wrong"); // R18
endmodule
`default_nettype wire

/* File: verification/asu_remote.sv */
// Purpose: remote serial transceiver facing the unit's line pins
// Assumes: bit time is a whole number of core clocks
// Notes: single mid-bit sample, so a glitch on the line at the sample point is misread
`timescale 1ns/1ps
`default_nettype none
module asu_remote #(
    parameter int BIT = 32
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic [7:0] rx_byte,
    output logic stop_ok,
    output int rx_cnt
);
    // start low, eight data lsb first, then the stop level the caller asks for
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (BIT) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    initial begin
        line_o = 1'b1;
        rx_cnt = 0;
        forever begin
            @(posedge clk_i);
            if (line_i === 1'b0) begin
                repeat (BIT / 2) @(posedge clk_i);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge clk_i);
                    rx_byte[i] = line_i;
                end
                repeat (BIT) @(posedge clk_i);
                stop_ok = line_i;
                rx_cnt++;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: register-level test of the asynchronous serial unit
// Assumes: divisor 1, so one bit is 32 core clocks
// Notes: waits on frames are bounded by thirty bit times, enough for preamble plus frame
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import asu_pkg::*;
    localparam int DIV = 1;
    localparam int BIT = 32 * DIV;
    logic core_clk_i, rst_b_i, wr_i, rd_i, txd_gpio_i, rxd;
    logic [2:0] addr_i;
    logic [15:0] wdata_i, rdata_o;
    logic txd_o, txd_oe_o, tx_req_o, rx_req_o, stop_ok;
    logic [7:0] rx_byte;
    int rx_cnt, c0;
    int miscompares = 0;
    int tests_run = 0;
    asu_top dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd),
        .txd_o(txd_o), .txd_oe_o(txd_oe_o), .txd_gpio_i(txd_gpio_i),
        .tx_req_o(tx_req_o), .rx_req_o(rx_req_o));
    asu_remote #(.BIT(BIT)) remote (.clk_i(core_clk_i), .line_i(txd_o), .line_o(rxd),
        .rx_byte(rx_byte), .stop_ok(stop_ok), .rx_cnt(rx_cnt));
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic finish_test;
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o & m, e);
    endtask
    // kind 0 waits for the receive request, kind 1 for a frame at the remote end
    task automatic wait_for(input int kind, input int cnt0);
        int n;
        n = 0;
        while ((kind == 0) ? (rx_req_o !== 1'b1) : (rx_cnt == cnt0)) begin
            @(posedge core_clk_i);
            n++;
            if (n > 30 * BIT) begin
                miscompares++;
                finish_test;
            end
        end
        #1;
    endtask
    initial begin
        rst_b_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 3'h0;
        wdata_i = 16'h0000;
        txd_gpio_i = 1'b1;
        repeat (10) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        rdc(OFS_RATE, 16'hffff, RATE_RST);
        rdc(OFS_CFG, 16'hffff, CFG_RST);
        rdc(OFS_STAT, 16'hffff, STAT_RST);
        rdc(3'h6, 16'hffff, 16'h0000);
        chk({15'h0000, txd_oe_o}, 16'h0000);
        txd_gpio_i <= 1'b0;
        wr(OFS_PIN, 16'h0001);
        chk({14'h0000, txd_oe_o, txd_o}, 16'h0002);
        txd_gpio_i <= 1'b1;
        // the low pulse looked like a start bit to the remote end; let it pass
        repeat (11 * BIT) @(posedge core_clk_i);
        wr(OFS_RATE, 16'(DIV));
        rdc(OFS_RATE, 16'h1fff, 16'h0001);
        wr(OFS_CFG, 16'h0203);
        rdc(OFS_CFG, 16'hffff, 16'h0203);
        for (int i = 0; i < 2; i++) begin
            rdc(OFS_STAT, 16'h0100, 16'h0100);
            c0 = rx_cnt;
            wr(OFS_DATA, i ? 16'h003c : 16'h00a5);
            wait_for(1, c0);
            chk({8'h00, rx_byte}, i ? 16'h003c : 16'h00a5);
            chk({15'h0000, stop_ok}, 16'h0001);
        end
        // even parity replaces bit 7: 0x43 has three ones in its low seven bits
        wr(OFS_CFG, 16'h020b);
        c0 = rx_cnt;
        wr(OFS_DATA, 16'h0043);
        wait_for(1, c0);
        chk({8'h00, rx_byte}, 16'h00c3);
        remote.send(8'h5a, 1'b1);
        wait_for(0, 0);
        rdc(OFS_STAT, 16'h004f, 16'h0040);
        rdc(OFS_DATA, 16'h00ff, 16'h005a);
        rdc(OFS_STAT, 16'h0040, 16'h0000);
        chk({15'h0000, rx_req_o}, 16'h0000);
        remote.send(8'h11, 1'b1);
        remote.send(8'h22, 1'b1);
        repeat (2 * BIT) @(posedge core_clk_i);
        rdc(OFS_STAT, 16'h0048, 16'h0048);
        rdc(OFS_STDA, 16'h00ff, 16'h0011);
        rdc(OFS_STAT, 16'h01c8, 16'h0180);
        fork
            remote.send(8'h77, 1'b1);
            rdc(OFS_STAT, 16'h0040, 16'h0000);
        join
        wait_for(0, 0);
        rdc(OFS_DATA, 16'h00ff, 16'h0077);
        rdc(OFS_STAT, 16'h0040, 16'h0040);
        rdc(OFS_DATA, 16'h00ff, 16'h0077);
        remote.send(8'h00, 1'b0);
        repeat (2 * BIT) @(posedge core_clk_i);
        rdc(OFS_STAT, 16'h0002, 16'h0002);
        wr(OFS_RATE, 16'h0000);
        wr(OFS_CFG, 16'h028b);
        chk({15'h0000, tx_req_o}, 16'h0001);
        rdc(OFS_STAT, 16'h0100, 16'h0100);
        c0 = rx_cnt;
        wr(OFS_DATA, 16'h0055);
        chk({15'h0000, tx_req_o}, 16'h0000);
        repeat (12 * BIT) @(posedge core_clk_i);
        chk(16'(rx_cnt - c0), 16'h0000);
        finish_test;
    end
endmodule
`default_nettype wire
